/* File: dma_flag_pkg.sv */
`default_nettype none
package dma_flag_pkg;
   // register byte offsets on the bus
   localparam logic [11:0] OFF_STATUS = 12'h000;
   localparam logic [11:0] OFF_CLEAR = 12'h004;
   localparam logic [11:0] OFF_MASK = 12'h008;
   // channel count and flags per channel
   localparam int NUM_CH = 8;
   localparam int FLAGS_PER_CH = 4;
   // flag order inside one channel's nibble
   localparam int FLAG_ANY = 0;
   localparam int FLAG_DONE = 1;
   localparam int FLAG_HALF = 2;
   localparam int FLAG_FAULT = 3;
   // values after reset, plus the all-ones nibble used by the clear-all
   localparam logic [31:0] STATUS_RST = 32'h0000_0000;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   localparam logic [3:0] NIBBLE_RST = 4'h0;
   localparam logic [3:0] NIBBLE_ALL = 4'hF;
endpackage : dma_flag_pkg
`default_nettype wire

/* File: dma_chan_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module dma_chan_flags (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic transfer_done_event_in,
   input wire logic halfway_event_in,
   input wire logic transfer_fault_event_in,
   input wire logic [3:0] clr_in,
   output logic [3:0] flags_out
);
   logic [3:0] flags_r;
   logic [3:0] flags_nxt;
   logic [3:0] set_w;
   logic [3:0] clr_w;

   always_comb begin
      set_w = dma_flag_pkg::NIBBLE_RST;
      set_w[dma_flag_pkg::FLAG_ANY] = transfer_done_event_in | halfway_event_in |
                                      transfer_fault_event_in;
      set_w[dma_flag_pkg::FLAG_DONE] = transfer_done_event_in;
      set_w[dma_flag_pkg::FLAG_HALF] = halfway_event_in;
      set_w[dma_flag_pkg::FLAG_FAULT] = transfer_fault_event_in;
      // global clear wipes the whole nibble
      clr_w = clr_in[dma_flag_pkg::FLAG_ANY] ? dma_flag_pkg::NIBBLE_ALL : clr_in;
      // set applied after clear so a same-cycle event survives
      flags_nxt = (flags_r & ~clr_w) | set_w;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags_r <= dma_flag_pkg::NIBBLE_RST;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign flags_out = flags_r;
endmodule : dma_chan_flags
`default_nettype wire

/* File: dma_channel_event_flags.sv */
// How it works
// - channel 4 halfway event sets bit 18, held until cleared
// - channel 4 fault event sets bit 19, held until cleared
// - any done, halfway or fault event sets that channel's any-event bit
// - channel 5 done event sets bit 21; zero means no completion
// - status is read-only; writing one to the clear register clears the bit, but an event at the same edge wins over any clear
// - nibble order any, done, halfway, fault; channel 6 uses bits 24 to 27
// - channel 7 any-event at bit 28, done at bit 29
// - all flags reset to zero; zero means no event since last clear
// - clear-all bit of a channel clears its four flags; zero does nothing
`timescale 1ns/1ps
`default_nettype none
module dma_channel_event_flags #(
   parameter int NUM_CH = dma_flag_pkg::NUM_CH
) (
   input wire logic CLK_SYS_IN,
   input wire logic RESET_N_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [3:0] PSTRB_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic [NUM_CH-1:0] TRANSFER_DONE_EVENT_IN,
   input wire logic [NUM_CH-1:0] HALFWAY_EVENT_IN,
   input wire logic [NUM_CH-1:0] TRANSFER_FAULT_EVENT_IN,
   output logic IRQ_OUT
);
   localparam int SW = NUM_CH * dma_flag_pkg::FLAGS_PER_CH;

   logic pready_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic irq_r;
   logic [31:0] mask_r;
   logic [31:0] status_w;
   logic [SW-1:0] flags_w;
   logic [31:0] strb_mask_w;
   logic [31:0] clear_w;
   logic acc_w;
   logic done_w;
   logic hit_status_w;
   logic hit_clear_w;
   logic hit_mask_w;
   logic mapped_w;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode: one wait state, pready from a flop
   assign acc_w = PSEL_IN & PENABLE_IN;
   assign done_w = acc_w & pready_r;
   assign hit_status_w = (PADDR_IN == dma_flag_pkg::OFF_STATUS);
   assign hit_clear_w = (PADDR_IN == dma_flag_pkg::OFF_CLEAR);
   assign hit_mask_w = (PADDR_IN == dma_flag_pkg::OFF_MASK);
   assign mapped_w = hit_status_w | hit_clear_w | hit_mask_w;

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_strb
         assign strb_mask_w[8*b+7:8*b] = {8{PSTRB_IN[b]}};
      end
   endgenerate

   // clear strobe only at the completing edge
   assign clear_w = (done_w & PWRITE_IN & hit_clear_w) ?
                    (PWDATA_IN & strb_mask_w) : dma_flag_pkg::STATUS_RST;

   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= acc_w & ~pready_r;
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         prdata_r <= dma_flag_pkg::RDATA_RST;
         pslverr_r <= 1'b0;
      end else if (acc_w & ~pready_r) begin
         pslverr_r <= ~mapped_w;
         if (!PWRITE_IN && hit_status_w) begin
            prdata_r <= status_w;
         end else if (!PWRITE_IN && hit_mask_w) begin
            prdata_r <= mask_r;
         end else begin
            // clear register and writes read back zero
            prdata_r <= dma_flag_pkg::RDATA_RST;
         end
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         mask_r <= dma_flag_pkg::MASK_RST;
      end else if (done_w && PWRITE_IN && hit_mask_w) begin
         mask_r <= (mask_r & ~strb_mask_w) | (PWDATA_IN & strb_mask_w);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-channel flag nibbles
   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_ch
         dma_chan_flags u_flags (
            .clk_in(CLK_SYS_IN),
            .rst_n_in(RESET_N_IN),
            .transfer_done_event_in(TRANSFER_DONE_EVENT_IN[c]),
            .halfway_event_in(HALFWAY_EVENT_IN[c]),
            .transfer_fault_event_in(TRANSFER_FAULT_EVENT_IN[c]),
            .clr_in(clear_w[4*c+3:4*c]),
            .flags_out(flags_w[4*c+3:4*c])
         );
      end
   endgenerate

   // channels beyond the word width are impossible; short configs pad zero
   always_comb begin
      status_w = dma_flag_pkg::STATUS_RST;
      status_w[SW-1:0] = flags_w;
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt: level, one cycle behind the flags
   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(status_w & mask_r);
      end
   end

   assign PRDATA_OUT = prdata_r;
   assign PREADY_OUT = pready_r;
   assign PSLVERR_OUT = pslverr_r;
   assign IRQ_OUT = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks; fixed to the default eight-channel map
   sequence seq_clear_write;
      PSEL_IN && PENABLE_IN && PWRITE_IN && pready_r && hit_clear_w;
   endsequence

   sequence seq_quiet6;
      !TRANSFER_DONE_EVENT_IN[6] && !HALFWAY_EVENT_IN[6] && !TRANSFER_FAULT_EVENT_IN[6];
   endsequence

   sequence seq_quiet4;
      !TRANSFER_DONE_EVENT_IN[4] && !HALFWAY_EVENT_IN[4] && !TRANSFER_FAULT_EVENT_IN[4];
   endsequence

   sequence seq_no_events;
      !(|TRANSFER_DONE_EVENT_IN) && !(|HALFWAY_EVENT_IN) && !(|TRANSFER_FAULT_EVENT_IN);
   endsequence

   sequence seq_first_access;
      PSEL_IN && PENABLE_IN && !pready_r;
   endsequence

   sequence seq_status_write;
      PSEL_IN && PENABLE_IN && PWRITE_IN && pready_r && hit_status_w;
   endsequence

   AST_HALF4_SET: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      HALFWAY_EVENT_IN[4] |=> status_w[18] && status_w[16])
      else $error("halfway event on channel 4 did not set bit 18");

   AST_FAULT4_SET: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      TRANSFER_FAULT_EVENT_IN[4] ##1 (!clear_w[19] && !clear_w[16])[*2]
      |-> status_w[19])
      else $error("fault on channel 4 not held at bit 19");

   AST_ANY5_SET: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (TRANSFER_DONE_EVENT_IN[5] || HALFWAY_EVENT_IN[5] || TRANSFER_FAULT_EVENT_IN[5])
      |=> status_w[20])
      else $error("any-event bit 20 missed");

   AST_DONE5_QUIET: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      !status_w[21] && !TRANSFER_DONE_EVENT_IN[5] |=> !status_w[21])
      else $error("bit 21 set without a completion");

   AST_CLEAR_BIT: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (seq_clear_write and seq_quiet6 and (PWDATA_IN[25] && PSTRB_IN[3]))
      |=> !status_w[25])
      else $error("clear write left bit 25 set");

   AST_CH6_LAYOUT: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      TRANSFER_FAULT_EVENT_IN[6] && !clear_w[24] |=> status_w[27] && status_w[24])
      else $error("channel 6 fault not at bits 27 and 24");

   AST_CH7_LAYOUT: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      TRANSFER_DONE_EVENT_IN[7] |=> status_w[29] && status_w[28])
      else $error("channel 7 done not at bits 29 and 28");

   AST_RESET_ZERO: assert property (
      @(posedge CLK_SYS_IN)
      !RESET_N_IN |-> status_w == dma_flag_pkg::STATUS_RST && !IRQ_OUT)
      else $error("flags not zero in reset");

   AST_CLEAR_ALL: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (seq_clear_write and seq_quiet6 and (PWDATA_IN[24] && PSTRB_IN[3]))
      |=> status_w[27:24] == dma_flag_pkg::NIBBLE_RST)
      else $error("clear-all left channel 6 flags");

   AST_SET_WINS: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      clear_w[17] && TRANSFER_DONE_EVENT_IN[4] |=> status_w[17])
      else $error("event lost against a clear");

   AST_STICKY: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      status_w[22] && !clear_w[22] && !clear_w[20] |=> status_w[22])
      else $error("flag dropped without a clear");

   AST_IRQ_LEVEL: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (|(status_w & mask_r)) |=> IRQ_OUT)
      else $error("unmasked flag without interrupt");

   AST_READY_ONE: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      PSEL_IN && !PENABLE_IN ##1 PSEL_IN && PENABLE_IN |=> PREADY_OUT)
      else $error("ready not one cycle into access");

   AST_HALF4_HOLD: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      status_w[18] && !clear_w[18] && !clear_w[16] |=> status_w[18])
      else $error("channel 4 halfway flag dropped without a clear");

   AST_DONE4_SET: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      TRANSFER_DONE_EVENT_IN[4] |=> status_w[17] && status_w[16])
      else $error("channel 4 done not at bits 17 and 16");

   AST_HALF5_SET: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      HALFWAY_EVENT_IN[5] |=> status_w[22] && status_w[20])
      else $error("channel 5 halfway not at bits 22 and 20");

   AST_FAULT5_SET: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      TRANSFER_FAULT_EVENT_IN[5] |=> status_w[23] && status_w[20])
      else $error("channel 5 fault not at bits 23 and 20");

   AST_DONE6_SET: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      TRANSFER_DONE_EVENT_IN[6] |=> status_w[25] && status_w[24])
      else $error("channel 6 done not at bits 25 and 24");

   AST_HALF6_SET: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      HALFWAY_EVENT_IN[6] |=> status_w[26] && status_w[24])
      else $error("channel 6 halfway not at bits 26 and 24");

   AST_ANY7_SET: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (TRANSFER_DONE_EVENT_IN[7] || HALFWAY_EVENT_IN[7] || TRANSFER_FAULT_EVENT_IN[7])
      |=> status_w[28])
      else $error("channel 7 any-event bit 28 missed");

   AST_CH6_QUIET: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (seq_quiet6 and (status_w[27:24] == dma_flag_pkg::NIBBLE_RST))
      |=> status_w[27:24] == dma_flag_pkg::NIBBLE_RST)
      else $error("channel 6 flag rose with no event");

   AST_CLEAR_ALL4: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (seq_clear_write and seq_quiet4 and (PWDATA_IN[16] && PSTRB_IN[2]))
      |=> status_w[19:16] == dma_flag_pkg::NIBBLE_RST)
      else $error("clear-all left channel 4 flags");

   AST_ZERO_KEEPS: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (seq_clear_write and (status_w[20] && !PWDATA_IN[20])) |=> status_w[20])
      else $error("zero in the clear register cleared bit 20");

   // events excluded: a set during the write is legal and would move the word
   AST_STATUS_RO: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (seq_status_write and seq_no_events) |=> status_w == $past(status_w))
      else $error("write to the status register changed a flag");

   AST_READ_STATUS: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (seq_first_access and (!PWRITE_IN && hit_status_w)) |=> PRDATA_OUT == $past(status_w))
      else $error("status read returned the wrong word");

   AST_READ_CLEAR_ZERO: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (seq_first_access and (!PWRITE_IN && hit_clear_w))
      |=> PRDATA_OUT == dma_flag_pkg::RDATA_RST)
      else $error("clear register read back nonzero");

   AST_MASK_WRITE: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      done_w && PWRITE_IN && hit_mask_w && PSTRB_IN == 4'hF |=> mask_r == $past(PWDATA_IN))
      else $error("full mask write did not land");

   AST_SLVERR_UNMAPPED: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (seq_first_access and !mapped_w) |=> PSLVERR_OUT && PREADY_OUT)
      else $error("unmapped access without slave error");

   AST_SLVERR_MAPPED: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      (seq_first_access and mapped_w) |=> !PSLVERR_OUT && PREADY_OUT)
      else $error("mapped access flagged as error");

   AST_IRQ_QUIET: assert property (
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      !(|(status_w & mask_r)) |=> !IRQ_OUT)
      else $error("interrupt with no unmasked flag");

   AST_RESET_BUS: assert property (
      @(posedge CLK_SYS_IN)
      !RESET_N_IN |-> !PREADY_OUT && !PSLVERR_OUT && PRDATA_OUT == dma_flag_pkg::RDATA_RST &&
      mask_r == dma_flag_pkg::MASK_RST)
      else $error("bus outputs or mask not cleared in reset");
endmodule : dma_channel_event_flags
`default_nettype wire

/* File: test_dma_channel_event_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module test_dma_channel_event_flags;
   typedef struct {int ch; int kind; logic [31:0] exp;} row_t;
   logic clk, rst_n, psel, pen, pwrite, pready, pslverr, irq, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0] pstrb;
   logic [7:0] done_ev, half_ev, fault_ev;
   int err_total, check_count;
   row_t rows [10];

   dma_channel_event_flags dut_u (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .TRANSFER_DONE_EVENT_IN(done_ev), .HALFWAY_EVENT_IN(half_ev),
      .TRANSFER_FAULT_EVENT_IN(fault_ev), .IRQ_OUT(irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task conclude;
      if (err_total == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // waits on pready, never on a fixed wait-state count
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 20) begin
         err_total++;
         $display("ERROR %0t bus wait timed out", $time);
         conclude();
      end
   endtask : apb

   task pulse(input int ch, input int kind);
      @(posedge clk);
      done_ev <= (kind == 0) ? 8'h01 << ch : 8'h00;
      half_ev <= (kind == 1) ? 8'h01 << ch : 8'h00;
      fault_ev <= (kind == 2) ? 8'h01 << ch : 8'h00;
      @(posedge clk);
      done_ev <= 8'h00;
      half_ev <= 8'h00;
      fault_ev <= 8'h00;
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, psel, pen, pwrite, rerr} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hF;
      {done_ev, half_ev, fault_ev} = 24'h00_0000;
      err_total = 0;
      check_count = 0;
      rows = '{'{4, 1, 32'h0005_0000}, '{4, 2, 32'h0009_0000}, '{5, 0, 32'h0030_0000},
         '{6, 0, 32'h0300_0000}, '{6, 1, 32'h0500_0000}, '{6, 2, 32'h0900_0000},
         '{7, 0, 32'h3000_0000}, '{0, 0, 32'h0000_0003},
         '{5, 1, 32'h0050_0000}, '{5, 2, 32'h0090_0000}};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, dma_flag_pkg::OFF_STATUS, 32'h0);
      chk(rdat, 32'h0000_0000);
      apb(1'b0, dma_flag_pkg::OFF_MASK, 32'h0);
      chk(rdat, 32'h0000_0000);
      foreach (rows[i]) begin
         pulse(rows[i].ch, rows[i].kind);
         apb(1'b0, dma_flag_pkg::OFF_STATUS, 32'h0);
         chk(rdat, rows[i].exp);
         apb(1'b1, dma_flag_pkg::OFF_CLEAR, 32'h0000_0001 << (4 * rows[i].ch));
         apb(1'b0, dma_flag_pkg::OFF_STATUS, 32'h0);
         chk(rdat, 32'h0000_0000);
      end
      pulse(5, 0);
      apb(1'b1, dma_flag_pkg::OFF_CLEAR, 32'h0000_0000);
      apb(1'b0, dma_flag_pkg::OFF_STATUS, 32'h0);
      chk(rdat, 32'h0030_0000);
      apb(1'b1, dma_flag_pkg::OFF_STATUS, 32'hFFFF_FFFF);
      apb(1'b0, dma_flag_pkg::OFF_STATUS, 32'h0);
      chk(rdat, 32'h0030_0000);
      // a lone done clear must leave the any-event bit behind
      apb(1'b1, dma_flag_pkg::OFF_CLEAR, 32'h0020_0000);
      apb(1'b0, dma_flag_pkg::OFF_STATUS, 32'h0);
      chk(rdat, 32'h0010_0000);
      apb(1'b1, dma_flag_pkg::OFF_MASK, 32'h0010_0000);
      apb(1'b0, dma_flag_pkg::OFF_MASK, 32'h0);
      chk(rdat, 32'h0010_0000);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0001);
      apb(1'b1, dma_flag_pkg::OFF_CLEAR, 32'h0010_0000);
      pulse(6, 1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
      // event held across the whole clear write, so both meet at one edge
      @(posedge clk);
      done_ev <= 8'h20;
      apb(1'b1, dma_flag_pkg::OFF_CLEAR, 32'h0010_0000);
      done_ev <= 8'h00;
      apb(1'b0, dma_flag_pkg::OFF_STATUS, 32'h0);
      chk(rdat, 32'h0530_0000);
      chk({31'h0, irq}, 32'h0000_0001);
      apb(1'b0, dma_flag_pkg::OFF_CLEAR, 32'h0);
      chk(rdat, 32'h0000_0000);
      apb(1'b0, 12'h00C, 32'h0);
      chk({31'h0, rerr}, 32'h0000_0001);
      apb(1'b0, dma_flag_pkg::OFF_MASK, 32'h0);
      chk({31'h0, rerr}, 32'h0000_0000);
      // byte strobes gate the clear: lane 3 off leaves bit 25 standing
      pulse(6, 0);
      pulse(5, 1);
      pstrb <= 4'h7;
      apb(1'b1, dma_flag_pkg::OFF_CLEAR, 32'h0200_0000);
      pstrb <= 4'hF;
      apb(1'b0, dma_flag_pkg::OFF_STATUS, 32'h0);
      chk(rdat, 32'h0770_0000);
      apb(1'b1, dma_flag_pkg::OFF_CLEAR, 32'h0200_0000);
      apb(1'b0, dma_flag_pkg::OFF_STATUS, 32'h0);
      chk(rdat, 32'h0570_0000);
      // channel 4 done held through a clear of its own done bit
      done_ev <= 8'h10;
      apb(1'b1, dma_flag_pkg::OFF_CLEAR, 32'h0002_0000);
      done_ev <= 8'h00;
      apb(1'b0, dma_flag_pkg::OFF_STATUS, 32'h0);
      chk(rdat, 32'h0573_0000);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
      rst_n <= 1'b1;
      apb(1'b0, dma_flag_pkg::OFF_STATUS, 32'h0);
      chk(rdat, 32'h0000_0000);
      apb(1'b0, dma_flag_pkg::OFF_MASK, 32'h0);
      chk(rdat, 32'h0000_0000);
      conclude();
   end
endmodule : test_dma_channel_event_flags
`default_nettype wire
